// *** include/mmd_consts.svh ***
// memory map decoder constants: offsets, ranges, reset values, codes
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH

// ==========================================================
// register offsets in the data space
`define MMD_FMC_ADDR 16'h0fd0
`define MMD_KEY_ADDR 16'h0fd1
`define MMD_SHADOW_ADDR 16'h0fd2

// ==========================================================
// reset values, field positions and codes
`define MMD_FMC_RESET 8'h40
`define MMD_COMMIT_KEY 8'hd5
`define MMD_LDR_EN_BIT 4
`define MMD_FILL_BYTE 8'hff
`define MMD_KEY_READ 8'h00

// ==========================================================
// address windows
`define MMD_PER1_LO 16'h0000
`define MMD_PER1_HI 16'h003f
`define MMD_PER2_LO 16'h0f00
`define MMD_PER2_HI 16'h0fff
`define MMD_PER3_LO 16'h0e40
`define MMD_PER3_HI 16'h0eff
`define MMD_RAM_LO 16'h0040
`define MMD_RAM_HI 16'h083f
`define MMD_LDR_LO 16'h1000
`define MMD_LDR_HI 16'h17ff
`define MMD_LDR_SERIAL_HI 16'h1fff
`define MMD_FLASH_LO 16'h8000
`define MMD_FLASH_HI 16'hffff

`endif

// *** include/mmd_pkg.sv ***
// memory map decoder types
`default_nettype none

package mmd_pkg;

    // ==========================================================
    // whole state of the decoder
    typedef struct packed {
        logic [7:0] hold;
        logic [7:0] shadow;
        logic [7:0] rdata;
        logic rvalid;
        logic [2:0] ser_sync;
        logic ser_mode;
    } mmd_state_t;

endpackage : mmd_pkg

`default_nettype wire

// *** logic/mmd_decoder.sv ***
// memory map decoder: code and data space selects, loader map control
`timescale 1ns/1ps
`default_nettype none
`include "mmd_consts.svh"

module mmd_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // serial programming mode pin
    input wire logic serial_mode_pin,
    // code fetch port
    input wire logic code_req,
    input wire logic [15:0] code_addr,
    output logic code_flash_sel,
    output logic code_loader_sel,
    // data port
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [15:0] data_addr,
    input wire logic [7:0] data_wdata,
    output logic [7:0] data_rdata,
    output logic data_rvalid,
    // data space selects
    output logic periph_sel,
    output logic ram_sel,
    output logic loader_sel,
    output logic flash_sel,
    // read data from the selected targets
    input wire logic [7:0] periph_rdata,
    input wire logic [7:0] ram_rdata,
    input wire logic [7:0] loader_rdata,
    input wire logic [7:0] flash_rdata,
    // committed loader map state
    output logic loader_rom_map_enable
);

    // ==========================================================
    // state
    mmd_pkg::mmd_state_t st;
    mmd_pkg::mmd_state_t next_st;

    logic d_per1, d_per2, d_per3, d_ram, d_ldr, d_ldr_ser, d_flash;
    logic c_ldr, c_ldr_ser, c_flash;
    logic hit_fmc, hit_key, hit_shadow, own_reg;
    logic ldr_on, d_ldr_ok, c_ldr_ok, access;
    logic [7:0] mux_rdata;

    // ==========================================================
    // address windows
    mmd_range #(.LO(`MMD_PER1_LO), .HI(`MMD_PER1_HI)) u_d_per1 (.addr(data_addr), .hit(d_per1));
    mmd_range #(.LO(`MMD_PER2_LO), .HI(`MMD_PER2_HI)) u_d_per2 (.addr(data_addr), .hit(d_per2));
    mmd_range #(.LO(`MMD_PER3_LO), .HI(`MMD_PER3_HI)) u_d_per3 (.addr(data_addr), .hit(d_per3));
    mmd_range #(.LO(`MMD_RAM_LO), .HI(`MMD_RAM_HI)) u_d_ram (.addr(data_addr), .hit(d_ram));
    mmd_range #(.LO(`MMD_LDR_LO), .HI(`MMD_LDR_HI)) u_d_ldr (.addr(data_addr), .hit(d_ldr));
    mmd_range #(.LO(`MMD_LDR_LO), .HI(`MMD_LDR_SERIAL_HI)) u_d_ldrs (.addr(data_addr), .hit(d_ldr_ser));
    mmd_range #(.LO(`MMD_FLASH_LO), .HI(`MMD_FLASH_HI)) u_d_flash (.addr(data_addr), .hit(d_flash));
    mmd_range #(.LO(`MMD_LDR_LO), .HI(`MMD_LDR_HI)) u_c_ldr (.addr(code_addr), .hit(c_ldr));
    mmd_range #(.LO(`MMD_LDR_LO), .HI(`MMD_LDR_SERIAL_HI)) u_c_ldrs (.addr(code_addr), .hit(c_ldr_ser));
    mmd_range #(.LO(`MMD_FLASH_LO), .HI(`MMD_FLASH_HI)) u_c_flash (.addr(code_addr), .hit(c_flash));

    // ==========================================================
    // decode
    assign hit_fmc = (data_addr == `MMD_FMC_ADDR);
    assign hit_key = (data_addr == `MMD_KEY_ADDR);
    assign hit_shadow = (data_addr == `MMD_SHADOW_ADDR);
    assign own_reg = hit_fmc || hit_key || hit_shadow;
    assign access = data_rd || data_wr;

    // the map only ever follows the committed shadow, never the holding copy
    assign ldr_on = st.shadow[`MMD_LDR_EN_BIT];
    // serial mode opens the wider loader window regardless of the map bit
    assign d_ldr_ok = st.ser_mode ? d_ldr_ser : (ldr_on && d_ldr);
    assign c_ldr_ok = st.ser_mode ? c_ldr_ser : (ldr_on && c_ldr);

    assign code_loader_sel = code_req && c_ldr_ok;
    assign code_flash_sel = code_req && c_flash;
    // our own registers sit inside the peripheral window and are answered here
    assign periph_sel = access && (d_per1 || d_per2 || d_per3) && !own_reg;
    // ram has no reset path; its contents are whatever the array holds
    assign ram_sel = access && d_ram;
    assign loader_sel = data_rd && d_ldr_ok;
    assign flash_sel = access && d_flash;
    assign loader_rom_map_enable = ldr_on;

    // ==========================================================
    // read data selection
    always_comb begin
        if (hit_fmc) begin
            mux_rdata = st.hold;
        end else if (hit_shadow) begin
            mux_rdata = st.shadow;
        end else if (hit_key) begin
            mux_rdata = `MMD_KEY_READ;
        end else if (d_per1 || d_per2 || d_per3) begin
            mux_rdata = periph_rdata;
        end else if (d_ram) begin
            mux_rdata = ram_rdata;
        end else if (d_ldr_ok) begin
            mux_rdata = loader_rdata;
        end else if (d_flash) begin
            mux_rdata = flash_rdata;
        end else begin
            // unmapped loader window and holes read as all ones
            mux_rdata = `MMD_FILL_BYTE;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.ser_sync = {st.ser_sync[1:0], serial_mode_pin};
        if (st.ser_sync[1] == st.ser_sync[2]) begin
            next_st.ser_mode = st.ser_sync[2];
        end
        next_st.rvalid = data_rd;
        if (data_rd) begin
            next_st.rdata = mux_rdata;
        end
        if (data_wr && hit_fmc) begin
            next_st.hold = data_wdata;
        end
        // copy in the key cycle itself so the following access sees it
        if (data_wr && hit_key && (data_wdata == `MMD_COMMIT_KEY)) begin
            next_st.shadow = st.hold;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st.hold <= `MMD_FMC_RESET;
            st.shadow <= `MMD_FMC_RESET;
            st.rdata <= 8'h00;
            st.rvalid <= 1'b0;
            st.ser_sync <= 3'h0;
            st.ser_mode <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign data_rdata = st.rdata;
    assign data_rvalid = st.rvalid;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_fmc_wr;
        data_wr && hit_fmc;
    endsequence

    sequence s_key_ok;
        data_wr && hit_key && (data_wdata == `MMD_COMMIT_KEY);
    endsequence

    sequence s_key_bad;
        data_wr && hit_key && (data_wdata != `MMD_COMMIT_KEY);
    endsequence

    chk_hold_no_effect: assert property (s_fmc_wr |=> $stable(st.shadow) && st.hold == $past(data_wdata))
        else $error("holding write changed the active map");
    chk_commit_copy: assert property (s_key_ok |=> st.shadow == $past(st.hold))
        else $error("commit key did not copy holding register");
    chk_bad_key: assert property (s_key_bad |=> $stable(st.shadow))
        else $error("reserved key value changed the shadow");
    chk_shadow_view: assert property (data_rd && hit_shadow |=> data_rvalid && data_rdata == $past(st.shadow))
        else $error("shadow view does not return active copy");
    chk_loader_off: assert property (!st.ser_mode && !ldr_on |-> !loader_sel && !code_loader_sel)
        else $error("loader rom selected while unmapped");
    chk_loader_on: assert property (ldr_on && code_req && c_ldr |-> code_loader_sel)
        else $error("mapped loader rom missed a fetch");
    chk_fill_read: assert property (data_rd && d_ldr && !ldr_on && !st.ser_mode
        |=> data_rdata == `MMD_FILL_BYTE)
        else $error("unmapped loader read did not return all ones");
    chk_loader_2k: assert property (loader_sel && !st.ser_mode |-> data_addr <= `MMD_LDR_HI)
        else $error("loader rom seen beyond 2 Kbytes");
    chk_flash_sel: assert property (code_req && code_addr[15] |-> code_flash_sel)
        else $error("flash missed a code fetch");
    chk_flash_data: assert property (data_rd && data_addr[15] |-> flash_sel ##1 data_rvalid)
        else $error("flash missed a data read");
    chk_periph_win: assert property (access && (data_addr >= `MMD_PER3_LO)
        && (data_addr <= `MMD_PER3_HI) |-> periph_sel)
        else $error("peripheral window not decoded");
    chk_ram_win: assert property (access && (data_addr >= `MMD_RAM_LO)
        && (data_addr <= `MMD_RAM_HI) |-> ram_sel && !periph_sel)
        else $error("ram window not decoded");
    chk_per1_win: assert property (access && (data_addr <= `MMD_PER1_HI) |-> periph_sel)
        else $error("low peripheral window not decoded");
    chk_per2_win: assert property (access && (data_addr >= `MMD_PER2_LO)
        && (data_addr <= `MMD_PER2_HI) && !own_reg |-> periph_sel)
        else $error("upper peripheral window not decoded");
    chk_flash_rdata: assert property (data_rd && data_addr[15] |=> data_rdata == $past(flash_rdata))
        else $error("flash read data not returned");

    // ==========================================================
    // reset default, key side effects and pin synchroniser
    sequence s_release;
        $rose(nrst);
    endsequence

    // the first enabled edge after release must still see the default map
    chk_reset_map: assert property (s_release |-> !ldr_on
        && st.shadow == `MMD_FMC_RESET && st.hold == `MMD_FMC_RESET)
        else $error("loader map not default after reset");
    chk_commit_next: assert property (s_key_ok
        |=> loader_rom_map_enable == $past(st.hold[`MMD_LDR_EN_BIT]))
        else $error("commit not visible on the next access");
    chk_key_no_hold: assert property (data_wr && hit_key |=> $stable(st.hold))
        else $error("key write disturbed the holding register");
    // a pin edge must survive two samples before the serial window moves
    chk_serial_hold: assert property (st.ser_sync[1] != st.ser_sync[2] |=> $stable(st.ser_mode))
        else $error("serial mode moved on an unsettled pin");
    chk_serial_take: assert property (st.ser_sync[1] == st.ser_sync[2]
        |=> st.ser_mode == $past(st.ser_sync[2]))
        else $error("serial mode did not follow a settled pin");

endmodule : mmd_decoder

`default_nettype wire

// *** logic/mmd_range.sv ***
// inclusive address window comparator
`timescale 1ns/1ps
`default_nettype none

module mmd_range #(
    parameter logic [15:0] LO = 16'h0000,
    parameter logic [15:0] HI = 16'hffff
) (
    // address under test
    input wire logic [15:0] addr,
    // window hit
    output logic hit
);

    assign hit = (addr >= LO) && (addr <= HI);

endmodule : mmd_range

`default_nettype wire

// *** tb/mmd_targets.sv ***
// far-side target models returning address-derived read data
`timescale 1ns/1ps
`default_nettype none
module mmd_targets (
    // clock and address
    input wire logic clk,
    input wire logic [15:0] addr,
    // selects
    input wire logic periph_sel,
    input wire logic ram_sel,
    input wire logic loader_sel,
    input wire logic flash_sel,
    // read data
    output logic [7:0] periph_rdata,
    output logic [7:0] ram_rdata,
    output logic [7:0] loader_rdata,
    output logic [7:0] flash_rdata
);
    // ==========================================================
    // unselected targets drive a changing pattern so a stray sample shows
    logic [7:0] junk = 8'h00;
    always @(posedge clk) junk <= junk + 8'h5b;
    assign periph_rdata = periph_sel ? (addr[7:0] ^ 8'h11) : junk;
    assign ram_rdata = ram_sel ? (addr[7:0] ^ 8'h22) : junk;
    assign loader_rdata = loader_sel ? (addr[7:0] ^ 8'h33) : junk;
    assign flash_rdata = flash_sel ? (addr[7:0] ^ 8'h44) : junk;
endmodule : mmd_targets
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
`include "mmd_consts.svh"
module tb_top;
    // ==========================================================
    // stimulus and observation
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic serial_mode_pin = 1'b0;
    logic code_req = 1'b0;
    logic [15:0] code_addr = 16'h0000;
    logic data_rd = 1'b0;
    logic data_wr = 1'b0;
    logic [15:0] data_addr = 16'h0000;
    logic [7:0] data_wdata = 8'h00;
    logic [7:0] data_rdata, periph_rdata, ram_rdata, loader_rdata, flash_rdata;
    logic data_rvalid, code_flash_sel, code_loader_sel, periph_sel, ram_sel;
    logic loader_sel, flash_sel, loader_rom_map_enable;
    int num_errors = 0;
    int checks = 0;
    always #5 clk = ~clk;
    mmd_decoder mmd_decoder_i (.clk, .nrst, .serial_mode_pin, .code_req, .code_addr, .code_flash_sel,
        .code_loader_sel, .data_rd, .data_wr, .data_addr, .data_wdata, .data_rdata, .data_rvalid,
        .periph_sel, .ram_sel, .loader_sel, .flash_sel, .periph_rdata, .ram_rdata, .loader_rdata,
        .flash_rdata, .loader_rom_map_enable);
    mmd_targets mmd_targets_i (.clk, .addr(data_addr), .periph_sel, .ram_sel, .loader_sel, .flash_sel,
        .periph_rdata, .ram_rdata, .loader_rdata, .flash_rdata);
    // ==========================================================
    // bus tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        data_wr <= 1'b1;
        data_addr <= a;
        data_wdata <= d;
        @(posedge clk);
        data_wr <= 1'b0;
    endtask : wr
    // answer is registered, so it is looked at just after the taking edge
    task automatic rdx(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        data_rd <= 1'b1;
        data_addr <= a;
        @(posedge clk);
        data_rd <= 1'b0;
        #1;
        chk({data_rvalid, data_rdata}, {1'b1, exp});
    endtask : rdx
    task automatic cf(input logic [15:0] a, input logic f, input logic l);
        @(posedge clk);
        code_req <= 1'b1;
        code_addr <= a;
        #1;
        chk({code_flash_sel, code_loader_sel}, {f, l});
    endtask : cf
    // ==========================================================
    // scenarios
    task automatic t_reset_map;
        chk(loader_rom_map_enable, 1'b0);
        rdx(`MMD_FMC_ADDR, `MMD_FMC_RESET);
        rdx(`MMD_SHADOW_ADDR, `MMD_FMC_RESET);
        rdx(16'h1000, 8'hff);
        rdx(16'h17ff, 8'hff);
        cf(16'h1000, 1'b0, 1'b0);
        cf(16'h8000, 1'b1, 1'b0);
        cf(16'hffff, 1'b1, 1'b0);
        cf(16'h7fff, 1'b0, 1'b0);
    endtask : t_reset_map
    task automatic t_windows;
        logic [15:0] a [13] = '{16'h0000, 16'h003f, 16'h0040, 16'h083f, 16'h0840, 16'h0e3f, 16'h0e40,
            16'h0eff, 16'h0f00, 16'h0fff, 16'h7fff, 16'h8000, 16'hffff};
        logic [7:0] k [13] = '{8'h11, 8'h11, 8'h22, 8'h22, 8'h00, 8'h00, 8'h11, 8'h11, 8'h11, 8'h11,
            8'h00, 8'h44, 8'h44};
        // only window edges and holes are touched, never a reserved peripheral register
        foreach (a[i]) rdx(a[i], (k[i] == 8'h00) ? 8'hff : (a[i][7:0] ^ k[i]));
    endtask : t_windows
    task automatic t_commit;
        logic [7:0] bad [3] = '{8'h00, 8'hd4, 8'hff};
        wr(`MMD_FMC_ADDR, 8'h50);
        rdx(`MMD_FMC_ADDR, 8'h50);
        rdx(`MMD_SHADOW_ADDR, 8'h40);
        rdx(16'h1000, 8'hff);
        foreach (bad[i]) begin
            wr(`MMD_KEY_ADDR, bad[i]);
            rdx(`MMD_SHADOW_ADDR, 8'h40);
        end
        wr(`MMD_KEY_ADDR, `MMD_COMMIT_KEY);
        rdx(16'h1000, 8'h33);
        chk(loader_rom_map_enable, 1'b1);
        rdx(16'h17ff, 8'hcc);
        rdx(16'h1800, 8'hff);
        rdx(`MMD_SHADOW_ADDR, 8'h50);
        rdx(`MMD_KEY_ADDR, `MMD_KEY_READ);
        cf(16'h17ff, 1'b0, 1'b1);
        cf(16'h1800, 1'b0, 1'b0);
        wr(`MMD_FMC_ADDR, `MMD_FMC_RESET);
        wr(`MMD_KEY_ADDR, `MMD_COMMIT_KEY);
        rdx(16'h1000, 8'hff);
    endtask : t_commit
    task automatic t_serial;
        @(posedge clk);
        serial_mode_pin <= 1'b1;
        repeat (6) @(posedge clk);
        rdx(16'h1800, 8'h33);
        cf(16'h1fff, 1'b0, 1'b1);
        cf(16'h2000, 1'b0, 1'b0);
        @(posedge clk);
        serial_mode_pin <= 1'b0;
        repeat (6) @(posedge clk);
        rdx(16'h1800, 8'hff);
    endtask : t_serial
    // holding write, key write and read on three adjacent edges
    task automatic adj_commit(input logic [7:0] v, input logic [7:0] exp);
        @(posedge clk);
        data_wr <= 1'b1;
        data_addr <= `MMD_FMC_ADDR;
        data_wdata <= v;
        @(posedge clk);
        data_addr <= `MMD_KEY_ADDR;
        data_wdata <= `MMD_COMMIT_KEY;
        @(posedge clk);
        data_wr <= 1'b0;
        data_rd <= 1'b1;
        data_addr <= 16'h1000;
        @(posedge clk);
        data_rd <= 1'b0;
        #1;
        chk({data_rvalid, data_rdata}, {1'b1, exp});
    endtask : adj_commit
    task automatic t_back_to_back;
        adj_commit(8'h10, 8'h33);
        adj_commit(`MMD_FMC_RESET, `MMD_FILL_BYTE);
    endtask : t_back_to_back
    // a reset in mid-run must drop a committed map
    task automatic t_reset_again;
        wr(`MMD_FMC_ADDR, 8'h10);
        wr(`MMD_KEY_ADDR, `MMD_COMMIT_KEY);
        rdx(`MMD_SHADOW_ADDR, 8'h10);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rdx(16'h1000, `MMD_FILL_BYTE);
        chk(loader_rom_map_enable, 1'b0);
        rdx(`MMD_SHADOW_ADDR, `MMD_FMC_RESET);
        rdx(`MMD_FMC_ADDR, `MMD_FMC_RESET);
    endtask : t_reset_again
    // ==========================================================
    // run control
    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset_map();
        t_windows();
        t_commit();
        t_back_to_back();
        t_reset_again();
        t_serial();
        test_done();
    end
    initial begin
        #20000;
        num_errors++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire
